/* bpm_monitor.sv */
// port checker of the pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module bpm_monitor
	import bpm_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic micro_mode,
	input wire logic [7:0] pe_in,
	input wire logic [7:0] pe_out,
	input wire logic [7:0] pe_oe_n,
	input wire logic [7:1] pf_in,
	input wire logic [7:1] pf_out,
	input wire logic [7:1] pf_oe_n,
	input wire logic [4:0] pg_in,
	input wire logic [2:0] pullup_en,
	input wire bpm_periph_req_s periph_req,
	input wire bpm_periph_rsp_s periph_rsp
);
	logic acc;
	logic wr;
	logic bus;
	// access phase, accepted write, bus ownership
	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	assign bus = periph_req.ext_bus_en;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// direction write and pin read steps
	sequence dir_wr(b);
		wr && paddr == BPM_OFS_PF_DIR && pwdata[7] == b;
	endsequence
	sequence pin_rd;
		$past(presetn, 2) && acc && !pwrite && paddr == BPM_OFS_PF_PIN;
	endsequence
	bus_answer_a: assert property (acc |-> pready)
		else $error("no ready");
	unmap_err_a: assert property (acc && paddr[1:0] == 2'b00
		|-> pslverr == (paddr > 8'h24)) else $error("slave error");
	dir_input_a: assert property (dir_wr(1'b1) |-> ##2 pf_oe_n[7])
		else $error("pin still driven");
	dir_output_a: assert property (dir_wr(1'b0) |-> ##2 !pf_oe_n[7])
		else $error("pin not driven");
	lat_drive_a: assert property (wr && paddr == BPM_OFS_PF_LAT
		|-> ##2 pf_out[7] == $past(pwdata[7], 2)) else $error("pin level");
	pin7_read_a: assert property (pin_rd
		|-> prdata[7] == $past(pf_in[7], 2) && !prdata[0])
		else $error("port read");
	bus_drive_a: assert property ($past(presetn && bus
		&& periph_req.ext_bus_drive) |-> pe_oe_n[7:6] == 2'b00
		&& pe_out[7:6] == $past(periph_req.ext_bus_out)) else $error("bus");
	bus_release_a: assert property ($past(presetn && bus
		&& !periph_req.ext_bus_drive) |-> pe_oe_n[7:6] == 2'b11)
		else $error("bus release");
	reset_idle_a: assert property ($rose(presetn)
		|-> pe_oe_n == 8'hFF && pf_oe_n == 7'h7F && pullup_en == 3'h0)
		else $error("reset state");
endmodule
bind bpm_port_mux bpm_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

/* bpm_pkg.sv */
// constants, register map and carrier types of the port pin multiplexer
package bpm_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] BPM_OFS_PE_PIN = 8'h00;
	localparam logic [7:0] BPM_OFS_PE_LAT = 8'h04;
	localparam logic [7:0] BPM_OFS_PE_DIR = 8'h08;
	localparam logic [7:0] BPM_OFS_PF_PIN = 8'h0C;
	localparam logic [7:0] BPM_OFS_PF_LAT = 8'h10;
	localparam logic [7:0] BPM_OFS_PF_DIR = 8'h14;
	localparam logic [7:0] BPM_OFS_PG_PIN = 8'h18;
	localparam logic [7:0] BPM_OFS_CMP = 8'h1C;
	localparam logic [7:0] BPM_OFS_ADC = 8'h20;
	localparam logic [7:0] BPM_OFS_CFG = 8'h24;

	// values after reset
	localparam logic [7:0] BPM_RST_LAT = 8'h00;
	localparam logic [7:0] BPM_RST_DIR = 8'hFF;
	localparam logic [7:0] BPM_RST_CMP = 8'h00;
	localparam logic [7:0] BPM_RST_ADC = 8'h00;
	localparam logic [7:0] BPM_RST_CFG = 8'h02;
	localparam logic [2:0] BPM_RST_PU = 3'h0;

	// field positions and codes
	localparam int BPM_CFG_U2SEL = 0;
	localparam int BPM_CFG_REMAP = 1;
	localparam int BPM_CFG_SDTRI = 2;
	localparam logic [2:0] BPM_CMP_OFF = 3'h7;
	localparam logic [2:0] BPM_CMP_OUT_MODE = 3'h3;
	localparam logic [3:0] BPM_PCFG_ALL_DIG = 4'hF;
	localparam logic [4:0] BPM_PF_AN_BASE = 5'h05;
	localparam int BPM_PF_LO = 1;
	localparam int BPM_PF_HI = 7;
	localparam int BPM_PF_CMP_LO = 3;
	localparam int BPM_PF_CMP_HI = 6;
	localparam int BPM_PE_PSP_WR = 1;
	localparam int BPM_PE_PSP_CS = 2;
	localparam int BPM_PE_BUS14 = 6;
	localparam int BPM_PE_BUS15 = 7;
	localparam int BPM_PG_J_PU = 0; // port j pullup is register bit 5

	// decoded register index
	typedef enum logic [3:0] {
		BPM_R_PE_PIN = 4'h0,
		BPM_R_PE_LAT = 4'h1,
		BPM_R_PE_DIR = 4'h2,
		BPM_R_PF_PIN = 4'h3,
		BPM_R_PF_LAT = 4'h4,
		BPM_R_PF_DIR = 4'h5,
		BPM_R_PG_PIN = 4'h6,
		BPM_R_CMP = 4'h7,
		BPM_R_ADC = 4'h8,
		BPM_R_CFG = 4'h9,
		BPM_R_NONE = 4'hF
	} bpm_reg_e;

	// peripheral requests toward the shared pins
	typedef struct packed {
		logic ext_bus_en;
		logic ext_bus_drive;
		logic [1:0] ext_bus_out;
		logic ccp2_en;
		logic ccp2_out;
		logic pwm2a_en;
		logic pwm2a_out;
		logic pwm1b_en;
		logic pwm1b_out;
		logic pwm_shutdown;
		logic psp_en;
		logic cmp1_out;
		logic cmp2_out;
	} bpm_periph_req_s;

	// pin levels handed back to the peripherals
	typedef struct packed {
		logic [1:0] ext_bus_in;
		logic ccp2_capture;
		logic psp_write;
		logic psp_select;
	} bpm_periph_rsp_s;

endpackage

/* bpm_port_mux.sv */
// port e/f/g pin multiplexer with apb register file
//
// Function
// - direction bit one makes pin input
// - direction bit zero drives latch onto pin
// - port f has pins seven down to one
// - latch reads back latched value, not pins
// - schmitt inputs, per-pin direction on port f
// - port f pins one-six serve comparators
// - reset makes rf6..rf1 analog, reading zero
// - external bus overrides everything on pin
// - large package: pins 6,7 carry bus 14,15
// - unit2 compare out, capture in on pin 7
// - unit2 on pin 7 if select clear, micro
// - pwm1 channel b on pin 6 when remapped
// - pwm overrides latch, optional shutdown tristate
// - port g: levels 4:0, pullups 7:5
// - port f pin seven purely digital
// - peripheral owns direction on don't-care functions
// - pins 1,2 are parallel port controls
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module bpm_port_mux
	import bpm_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter bit LARGE_PKG = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic micro_mode,
	input wire logic [7:0] pe_in,
	output logic [7:0] pe_out,
	output logic [7:0] pe_oe_n,
	input wire logic [7:1] pf_in,
	output logic [7:1] pf_out,
	output logic [7:1] pf_oe_n,
	input wire logic [4:0] pg_in,
	output logic [2:0] pullup_en,
	input wire bpm_periph_req_s periph_req,
	output bpm_periph_rsp_s periph_rsp
);

	////////////////////////////////////////////////////////////////////////
	// parameter checks

	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("address width must be 8 to 32");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [7:0] pe_lat;
		logic [7:0] pe_dir;
		logic [7:1] pf_lat;
		logic [7:1] pf_dir;
		logic [2:0] pg_pu;
		logic [7:0] cmp;
		logic [7:0] adc;
		logic [7:0] cfg;
		logic [7:0] pe_sync;
		logic [7:1] pf_sync;
		logic [4:0] pg_sync;
		logic [7:0] pe_out;
		logic [7:0] pe_oe_n;
		logic [7:1] pf_out;
		logic [7:1] pf_oe_n;
		logic [31:0] prdata;
	} bpm_state_s;

	bpm_state_s s_r;
	bpm_state_s s_nxt;

	////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// maps a bus address to a register index
	function automatic bpm_reg_e bpm_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] lo;
		lo = a[7:0];
		if (ADDR_W > 8 && (a >> 8) != '0) begin
			return BPM_R_NONE;
		end
		unique case (lo)
			BPM_OFS_PE_PIN: return BPM_R_PE_PIN;
			BPM_OFS_PE_LAT: return BPM_R_PE_LAT;
			BPM_OFS_PE_DIR: return BPM_R_PE_DIR;
			BPM_OFS_PF_PIN: return BPM_R_PF_PIN;
			BPM_OFS_PF_LAT: return BPM_R_PF_LAT;
			BPM_OFS_PF_DIR: return BPM_R_PF_DIR;
			BPM_OFS_PG_PIN: return BPM_R_PG_PIN;
			BPM_OFS_CMP: return BPM_R_CMP;
			BPM_OFS_ADC: return BPM_R_ADC;
			BPM_OFS_CFG: return BPM_R_CFG;
			default: return BPM_R_NONE;
		endcase
	endfunction

	// true when port f pin i is in analog mode
	function automatic logic bpm_pf_analog(input int i,
			input logic [7:0] adc, input logic [7:0] cmp);
		logic [4:0] chan;
		logic cmp_on;
		chan = BPM_PF_AN_BASE + 5'(i);
		cmp_on = (cmp[2:0] != BPM_CMP_OFF);
		if (i == BPM_PF_HI) begin
			return 1'b0;
		end
		if (cmp_on && i >= BPM_PF_CMP_LO && i <= BPM_PF_CMP_HI) begin
			return 1'b1;
		end
		if (adc[3:0] == BPM_PCFG_ALL_DIG) begin
			return 1'b0;
		end
		return (5'(adc[3:0]) + chan) < 5'd15;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// combinational decode of routing

	bpm_reg_e sel;
	logic wr_en;
	logic u2_routed;
	logic pwm_tri;
	logic bus_owns;
	logic [7:1] pf_digital;

	always_comb begin
		sel = bpm_decode(paddr);
		wr_en = psel && penable && pwrite && pstrb[0] && sel != BPM_R_NONE;
		u2_routed = !s_r.cfg[BPM_CFG_U2SEL] && micro_mode;
		pwm_tri = periph_req.pwm_shutdown && s_r.cfg[BPM_CFG_SDTRI];
		bus_owns = LARGE_PKG && periph_req.ext_bus_en;
		for (int i = BPM_PF_LO; i <= BPM_PF_HI; i++) begin
			pf_digital[i] = bpm_pf_analog(i, s_r.adc, s_r.cmp) ?
				1'b0 : s_r.pf_sync[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_nxt = s_r;
		// schmitt inputs taken once per clock
		s_nxt.pe_sync = pe_in;
		s_nxt.pf_sync = pf_in;
		s_nxt.pg_sync = pg_in;

		// register writes on the access edge
		if (wr_en) begin
			unique case (sel)
				BPM_R_PE_PIN, BPM_R_PE_LAT: begin
					s_nxt.pe_lat = pwdata[7:0];
				end
				BPM_R_PE_DIR: begin
					s_nxt.pe_dir = pwdata[7:0];
				end
				BPM_R_PF_PIN, BPM_R_PF_LAT: begin
					s_nxt.pf_lat = pwdata[7:1];
				end
				BPM_R_PF_DIR: begin
					s_nxt.pf_dir = pwdata[7:1];
				end
				BPM_R_PG_PIN: begin
					s_nxt.pg_pu = pwdata[7:5];
					if (!LARGE_PKG) begin
						s_nxt.pg_pu[BPM_PG_J_PU] = 1'b0;
					end
				end
				BPM_R_CMP: begin
					s_nxt.cmp = {2'b00, pwdata[5:0]};
				end
				BPM_R_ADC: begin
					s_nxt.adc = {2'b00, pwdata[5:0]};
				end
				BPM_R_CFG: begin
					s_nxt.cfg = {5'b00000, pwdata[2:0]};
				end
				BPM_R_NONE: begin
				end
			endcase
		end

		// read data captured in the setup cycle
		if (psel && !penable) begin
			unique case (sel)
				BPM_R_PE_PIN: s_nxt.prdata = {24'h0, s_r.pe_sync};
				BPM_R_PE_LAT: s_nxt.prdata = {24'h0, s_r.pe_lat};
				BPM_R_PE_DIR: s_nxt.prdata = {24'h0, s_r.pe_dir};
				BPM_R_PF_PIN: s_nxt.prdata = {24'h0, pf_digital, 1'b0};
				BPM_R_PF_LAT: s_nxt.prdata = {24'h0, s_r.pf_lat, 1'b0};
				BPM_R_PF_DIR: s_nxt.prdata = {24'h0, s_r.pf_dir, 1'b0};
				BPM_R_PG_PIN: s_nxt.prdata = {24'h0, s_r.pg_pu, s_r.pg_sync};
				BPM_R_CMP: s_nxt.prdata = {24'h0, periph_req.cmp2_out,
					periph_req.cmp1_out, s_r.cmp[5:0]};
				BPM_R_ADC: s_nxt.prdata = {24'h0, s_r.adc};
				BPM_R_CFG: s_nxt.prdata = {24'h0, s_r.cfg};
				BPM_R_NONE: s_nxt.prdata = 32'h0000_0000;
			endcase
		end

		// port e: latch and direction by default
		for (int i = 0; i < 8; i++) begin
			s_nxt.pe_out[i] = s_r.pe_lat[i];
			s_nxt.pe_oe_n[i] = s_r.pe_dir[i];
		end
		// parallel port controls force inputs
		if (periph_req.psp_en) begin
			s_nxt.pe_oe_n[BPM_PE_PSP_WR] = 1'b1;
			s_nxt.pe_oe_n[BPM_PE_PSP_CS] = 1'b1;
		end
		// pwm1 channel b on pin 6
		if (LARGE_PKG && s_r.cfg[BPM_CFG_REMAP] && periph_req.pwm1b_en) begin
			s_nxt.pe_out[BPM_PE_BUS14] = periph_req.pwm1b_out;
			s_nxt.pe_oe_n[BPM_PE_BUS14] = pwm_tri;
		end
		// unit2 compare output over port data when direction is zero
		if (u2_routed && periph_req.ccp2_en && !s_r.pe_dir[BPM_PE_BUS15]) begin
			s_nxt.pe_out[BPM_PE_BUS15] = periph_req.ccp2_out;
		end
		// pwm2 channel a on pin 7
		if (u2_routed && periph_req.pwm2a_en) begin
			s_nxt.pe_out[BPM_PE_BUS15] = periph_req.pwm2a_out;
			s_nxt.pe_oe_n[BPM_PE_BUS15] = pwm_tri;
		end
		// external bus wins over everything on its pins
		if (bus_owns) begin
			s_nxt.pe_out[BPM_PE_BUS14] = periph_req.ext_bus_out[0];
			s_nxt.pe_out[BPM_PE_BUS15] = periph_req.ext_bus_out[1];
			s_nxt.pe_oe_n[BPM_PE_BUS14] = !periph_req.ext_bus_drive;
			s_nxt.pe_oe_n[BPM_PE_BUS15] = !periph_req.ext_bus_drive;
		end

		// port f: latch drive, unaffected by analog mode
		for (int i = BPM_PF_LO; i <= BPM_PF_HI; i++) begin
			s_nxt.pf_out[i] = s_r.pf_lat[i];
			s_nxt.pf_oe_n[i] = s_r.pf_dir[i];
		end
		// comparator outputs take priority over port data
		if (s_r.cmp[2:0] == BPM_CMP_OUT_MODE) begin
			s_nxt.pf_out[1] = periph_req.cmp2_out;
			s_nxt.pf_out[2] = periph_req.cmp1_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r.pe_lat <= BPM_RST_LAT;
			s_r.pe_dir <= BPM_RST_DIR;
			s_r.pf_lat <= BPM_RST_LAT[7:1];
			s_r.pf_dir <= BPM_RST_DIR[7:1];
			s_r.pg_pu <= BPM_RST_PU;
			s_r.cmp <= BPM_RST_CMP;
			s_r.adc <= BPM_RST_ADC;
			s_r.cfg <= BPM_RST_CFG;
			s_r.pe_sync <= 8'h00;
			s_r.pf_sync <= 7'h00;
			s_r.pg_sync <= 5'h00;
			s_r.pe_out <= 8'h00;
			s_r.pe_oe_n <= 8'hFF;
			s_r.pf_out <= 7'h00;
			s_r.pf_oe_n <= 7'h7F;
			s_r.prdata <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// zero-wait apb answer
	assign pready = 1'b1;
	assign pslverr = psel && penable && sel == BPM_R_NONE;
	assign prdata = s_r.prdata;

	// pin drivers straight from flops
	assign pe_out = s_r.pe_out;
	assign pe_oe_n = s_r.pe_oe_n;
	assign pf_out = s_r.pf_out;
	assign pf_oe_n = s_r.pf_oe_n;
	assign pullup_en = s_r.pg_pu;

	// sampled pin levels back to peripherals
	assign periph_rsp.ext_bus_in = bus_owns ?
		{s_r.pe_sync[BPM_PE_BUS15], s_r.pe_sync[BPM_PE_BUS14]} : 2'b00;
	assign periph_rsp.ccp2_capture = u2_routed && s_r.pe_dir[BPM_PE_BUS15] &&
		s_r.pe_sync[BPM_PE_BUS15];
	assign periph_rsp.psp_write = s_r.pe_sync[BPM_PE_PSP_WR];
	assign periph_rsp.psp_select = s_r.pe_sync[BPM_PE_PSP_CS];

endmodule

`default_nettype wire

/* tb_top.sv */
// self-checking bench of the port pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import bpm_pkg::*;
	;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, micro_mode = 1'b0, pready, pslverr, e;
	logic [7:0] paddr = 8'h00, pe_ext = 8'h00, pe_out, pe_oe_n;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0] pstrb = 4'hF;
	logic [7:1] pf_ext = 7'h00, pf_out, pf_oe_n;
	logic [4:0] pg_in = 5'h00;
	logic [2:0] pullup_en;
	wire logic [7:0] pe_in;
	wire logic [7:1] pf_in;
	bpm_periph_req_s periph_req = '0;
	bpm_periph_rsp_s periph_rsp;
	int errors = 0, n_checks = 0;
	// pin level: the design's driver wins over the outside
	assign pe_in = (pe_oe_n & pe_ext) | (~pe_oe_n & pe_out);
	assign pf_in = (pf_oe_n & pf_ext) | (~pf_oe_n & pf_out);
	bpm_port_mux dut (.*);
	// 10 MHz clock
	initial begin
		forever #50 pclk = ~pclk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one apb transfer, waits for ready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			errors++;
			end_of_test;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk(q, x);
	endtask
	// registered pins settle one edge later
	task automatic wt;
		@(posedge pclk);
		@(negedge pclk);
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		chk({pullup_en, pf_oe_n, pe_oe_n}, 32'h7FFF);
		@(posedge pclk);
		pf_ext <= 7'h7F;
		pg_in <= 5'h15;
		rdc(BPM_OFS_PF_PIN, 32'h80);
		apb(1'b1, BPM_OFS_PG_PIN, 8'hFF);
		rdc(BPM_OFS_PG_PIN, 32'hF5);
		chk(pullup_en, 3'h7);
	endtask
	task automatic t_pf;
		apb(1'b1, BPM_OFS_CMP, BPM_CMP_OFF);
		apb(1'b1, BPM_OFS_ADC, 8'h0F);
		apb(1'b1, BPM_OFS_PF_DIR, 8'hCE);
		apb(1'b1, BPM_OFS_PF_LAT, 8'hFF);
		wt;
		chk({pf_oe_n, pf_out[5:4]}, {7'h67, 2'h3});
		@(posedge pclk);
		pf_ext <= 7'h55;
		rdc(BPM_OFS_PF_LAT, 32'hFE);
		rdc(BPM_OFS_PF_PIN, 32'hBA);
	endtask
	task automatic t_cmp;
		apb(1'b1, BPM_OFS_PF_DIR, 8'h00);
		apb(1'b1, BPM_OFS_CMP, 8'h03);
		periph_req.cmp1_out <= 1'b1;
		wt;
		chk(pf_out[2:1], 2'b10);
		rdc(BPM_OFS_PF_PIN, 32'h84);
		apb(1'b1, BPM_OFS_CMP, BPM_CMP_OFF);
		// pin 1 leaves comparator drive one edge later, sampled one after
		wt;
		rdc(BPM_OFS_PF_PIN, 32'hFE);
	endtask
	task automatic t_pe;
		apb(1'b1, BPM_OFS_PE_DIR, 8'h00);
		apb(1'b1, BPM_OFS_PE_PIN, 8'hE5);
		rdc(BPM_OFS_PE_LAT, 32'hE5);
		chk({pe_oe_n, pe_out}, 32'h00E5);
		apb(1'b1, BPM_OFS_CFG, 8'h07);
		periph_req.pwm1b_en <= 1'b1;
		wt;
		chk(pe_out[6], 1'b0);
		@(posedge pclk);
		periph_req.pwm_shutdown <= 1'b1;
		wt;
		chk(pe_oe_n[6], 1'b1);
		@(posedge pclk);
		periph_req.ext_bus_en <= 1'b1;
		periph_req.ext_bus_drive <= 1'b1;
		periph_req.ext_bus_out <= 2'b01;
		wt;
		chk({pe_oe_n[7:6], pe_out[7:6]}, 4'h1);
		@(posedge pclk);
		periph_req.ext_bus_drive <= 1'b0;
		periph_req.psp_en <= 1'b1;
		pe_ext <= 8'hC6;
		wt;
		wt;
		chk({pe_oe_n[7:6], pe_oe_n[2:1], periph_rsp}, 32'h1FB);
		@(posedge pclk);
		periph_req <= '0;
	endtask
	task automatic t_ccp;
		apb(1'b1, BPM_OFS_CFG, 8'h02);
		micro_mode <= 1'b1;
		periph_req.ccp2_en <= 1'b1;
		wt;
		chk(pe_out[7], 1'b0);
		@(posedge pclk);
		micro_mode <= 1'b0;
		wt;
		chk(pe_out[7], 1'b1);
		@(posedge pclk);
		micro_mode <= 1'b1;
		pe_ext <= 8'h80;
		apb(1'b1, BPM_OFS_PE_DIR, 8'h80);
		wt;
		wt;
		chk({pe_oe_n[7], periph_rsp.ccp2_capture}, 2'b11);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		t_reset;
		t_pf;
		t_cmp;
		t_pe;
		t_ccp;
		rdc(8'h28, 32'h0);
		chk(e, 1'b1);
		end_of_test;
	end
endmodule
`default_nettype wire
